// File: pmm_pkg.sv
// shared constants and carrier types for the paged memory mapper
package pmm_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int MAP_COUNT   = 32;
  localparam int MAP_W       = 5;
  localparam int LPAGE_W     = 5;
  localparam int OFFSET_W    = 11;
  localparam int PPAGE_W     = 7;
  localparam int ENTRY_W     = 8;
  localparam int ENTRY_IDX_W = MAP_W + LPAGE_W;
  localparam int PHYS_W      = PPAGE_W + OFFSET_W;
  localparam int CARD_BIT    = 7;

  // ----------------------------------------------------------------
  // logical address decode
  // ----------------------------------------------------------------
  localparam logic [4:0] MAPRAM_LPAGE = 5'h1e;
  localparam logic [2:0] PERIPH_TOP3  = 3'h7;
  localparam logic [1:0] GFX_TOP2     = 2'h2;
  localparam int         TGT_LSB      = 5;
  localparam logic [1:0] TGT_ALL      = 2'h0;
  localparam logic [1:0] TGT_A        = 2'h1;
  localparam logic [1:0] TGT_B        = 2'h2;

  // ----------------------------------------------------------------
  // apb register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_STATE  = 8'h00;
  localparam logic [7:0] REG_P1MAP  = 8'h04;
  localparam logic [7:0] REG_P2MAP  = 8'h08;
  localparam logic [7:0] REG_PDIS   = 8'h0c;
  localparam logic [7:0] REG_GFXEN  = 8'h10;
  localparam logic [7:0] REG_DMAMAP = 8'h14;
  localparam logic [7:0] REG_STATUS = 8'h18;

  localparam int PMAP_A_LSB   = 0;
  localparam int PMAP_B_LSB   = 8;
  localparam int DMAMAP_STEP  = 5;
  localparam int STAT_CARD    = 0;
  localparam int STAT_PEN_LSB = 4;
  localparam int STAT_DMA_LSB = 8;

  localparam logic [4:0]  MAP_A_RST  = 5'h00;
  localparam logic [4:0]  MAP_B_RST  = 5'h00;
  localparam logic [31:0] PDIS_RST   = 32'h0000_0000;
  localparam logic [31:0] GFXEN_RST  = 32'h0000_0000;
  localparam logic [4:0]  DMAMAP_RST = 5'h00;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } pmm_req_t;

  typedef struct packed {
    logic              valid;
    logic              map_wr;
    logic              ram_sel;
    logic              card_hit;
    logic              periph_sel;
    logic              gfx_sel;
    logic [PHYS_W-1:0] phys_addr;
  } pmm_resp_t;

endpackage : pmm_pkg

// File: pmm_map_store.sv
// map entry storage: several write ports, several combinational reads
`timescale 1ns/1ps
`default_nettype none
module pmm_map_store #(
  parameter int ENTRIES = 1024,
  parameter int IDX_W   = 10,
  parameter int DATA_W  = 8,
  parameter int WPORTS  = 4,
  parameter int RPORTS  = 3
) (
  input  wire logic                          mclk,
  input  wire logic [WPORTS-1:0]             wr_en,
  input  wire logic [WPORTS-1:0][IDX_W-1:0]  wr_idx,
  input  wire logic [WPORTS-1:0][DATA_W-1:0] wr_data,
  input  wire logic [RPORTS-1:0][IDX_W-1:0]  rd_idx,
  output logic      [RPORTS-1:0][DATA_W-1:0] rd_data
);

  logic [DATA_W-1:0] mem [ENTRIES];

  // later ports win on a same-entry collision
  always_ff @(posedge mclk) begin
    for (int i = 0; i < WPORTS; i++) begin
      if (wr_en[i]) begin
        mem[wr_idx[i]] <= wr_data[i];
      end
    end
  end

  // reads never wait for writes, so lookups are never held off
  for (genvar r = 0; r < RPORTS; r++) begin : g_rd
    assign rd_data[r] = mem[rd_idx[r]];
  end

endmodule : pmm_map_store
`default_nettype wire

// File: pmm_mapper.sv
// paged memory mapper: two processor ports, dma port, apb registers
`timescale 1ns/1ps
`default_nettype none
module pmm_mapper #(
  parameter int DMA_CH = 3
) (
  input  wire logic                  mclk,
  input  wire logic                  reset,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire pmm_pkg::pmm_req_t     proc_req [2],
  output pmm_pkg::pmm_resp_t         proc_resp [2],
  input  wire logic [1:0]            irq_taken,
  input  wire logic                  dma_valid,
  input  wire logic [15:0]           dma_addr,
  output pmm_pkg::pmm_resp_t         dma_resp,
  input  wire logic [DMA_CH-1:0]     dma_claim,
  input  wire logic                  card_id_pin,
  input  wire logic [1:0]            peripheral_enable_input,
  output logic      [1:0]            periph_enable_out,
  output logic                       periph_enable_oe,
  output logic      [1:0]            graphics_ram_enable,
  output logic                       graphics_ram_enable_oe
);

  localparam int SYNC_W = DMA_CH + 3;
  localparam int IW     = pmm_pkg::ENTRY_IDX_W;
  localparam int EW     = pmm_pkg::ENTRY_W;
  localparam int MW     = pmm_pkg::MAP_W;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [SYNC_W-1:0] pin_meta_q;
  logic [SYNC_W-1:0] pin_sync_q;
  logic [DMA_CH-1:0] claim_s;
  logic [1:0]        pen_s;
  logic              card_s;

  always_ff @(posedge mclk) begin
    if (reset) begin
      pin_meta_q <= '0;
      pin_sync_q <= '0;
    end else begin
      pin_meta_q <= {dma_claim, peripheral_enable_input, card_id_pin};
      pin_sync_q <= pin_meta_q;
    end
  end

  assign card_s  = pin_sync_q[0];
  assign pen_s   = pin_sync_q[2:1];
  assign claim_s = pin_sync_q[SYNC_W-1:3];

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  logic        apb_wr;
  logic        apb_setup;
  logic        addr_ok;
  logic [31:0] rd_mux;
  logic [1:0]  state_q;
  logic [MW-1:0] map_a_q [2];
  logic [MW-1:0] map_b_q [2];
  logic [31:0] pdis_q;
  logic [31:0] gfxen_q;
  logic [DMA_CH-1:0][MW-1:0] dmamap_q;

  assign pready    = 1'b1;
  assign apb_setup = psel && !penable;
  assign apb_wr    = psel && penable && pwrite && addr_ok;

  always_comb begin
    addr_ok = 1'b1;
    rd_mux  = '0;
    case (paddr)
      pmm_pkg::REG_STATE: rd_mux[1:0] = state_q;
      pmm_pkg::REG_P1MAP: begin
        rd_mux[pmm_pkg::PMAP_A_LSB +: MW] = map_a_q[0];
        rd_mux[pmm_pkg::PMAP_B_LSB +: MW] = map_b_q[0];
      end
      pmm_pkg::REG_P2MAP: begin
        rd_mux[pmm_pkg::PMAP_A_LSB +: MW] = map_a_q[1];
        rd_mux[pmm_pkg::PMAP_B_LSB +: MW] = map_b_q[1];
      end
      pmm_pkg::REG_PDIS:   rd_mux = pdis_q;
      pmm_pkg::REG_GFXEN:  rd_mux = gfxen_q;
      pmm_pkg::REG_DMAMAP: rd_mux[DMA_CH*MW-1:0] = dmamap_q;
      pmm_pkg::REG_STATUS: begin
        rd_mux[pmm_pkg::STAT_CARD] = card_s;
        rd_mux[pmm_pkg::STAT_PEN_LSB +: 2] = pen_s;
        rd_mux[pmm_pkg::STAT_DMA_LSB +: DMA_CH] = claim_s;
      end
      default: addr_ok = 1'b0;
    endcase
  end

  assign pslverr = psel && penable && !addr_ok;

  always_ff @(posedge mclk) begin
    if (reset) begin
      prdata <= '0;
    end else if (apb_setup) begin
      prdata <= rd_mux;
    end
  end

  // state bits: an interrupt forces A even against a software write
  always_ff @(posedge mclk) begin
    if (reset) begin
      state_q <= 2'h0;
    end else begin
      if (apb_wr && paddr == pmm_pkg::REG_STATE) begin
        state_q <= pwdata[1:0];
      end
      for (int i = 0; i < 2; i++) begin
        if (irq_taken[i]) begin
          state_q[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      for (int i = 0; i < 2; i++) begin
        map_a_q[i] <= pmm_pkg::MAP_A_RST;
        map_b_q[i] <= pmm_pkg::MAP_B_RST;
      end
    end else if (apb_wr) begin
      if (paddr == pmm_pkg::REG_P1MAP) begin
        map_a_q[0] <= pwdata[pmm_pkg::PMAP_A_LSB +: MW];
        map_b_q[0] <= pwdata[pmm_pkg::PMAP_B_LSB +: MW];
      end
      if (paddr == pmm_pkg::REG_P2MAP) begin
        map_a_q[1] <= pwdata[pmm_pkg::PMAP_A_LSB +: MW];
        map_b_q[1] <= pwdata[pmm_pkg::PMAP_B_LSB +: MW];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      pdis_q   <= pmm_pkg::PDIS_RST;
      gfxen_q  <= pmm_pkg::GFXEN_RST;
      dmamap_q <= {DMA_CH{pmm_pkg::DMAMAP_RST}};
    end else if (apb_wr) begin
      if (paddr == pmm_pkg::REG_PDIS) begin
        pdis_q <= pwdata;
      end
      if (paddr == pmm_pkg::REG_GFXEN) begin
        gfxen_q <= pwdata;
      end
      if (paddr == pmm_pkg::REG_DMAMAP) begin
        dmamap_q <= pwdata[DMA_CH*MW-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // map storage
  // ----------------------------------------------------------------
  logic [3:0]         wr_en;
  logic [3:0][IW-1:0] wr_idx;
  logic [3:0][EW-1:0] wr_data;
  logic [2:0][IW-1:0] rd_idx;
  logic [2:0][EW-1:0] rd_data;

  pmm_map_store #(
    .ENTRIES (pmm_pkg::MAP_COUNT << pmm_pkg::LPAGE_W),
    .IDX_W   (IW),
    .DATA_W  (EW),
    .WPORTS  (4),
    .RPORTS  (3)
  ) u_store (
    .mclk    (mclk),
    .wr_en   (wr_en),
    .wr_idx  (wr_idx),
    .wr_data (wr_data),
    .rd_idx  (rd_idx),
    .rd_data (rd_data)
  );

  // ----------------------------------------------------------------
  // processor ports
  // ----------------------------------------------------------------
  logic [1:0] pdis_cur;
  logic [1:0] gfx_cur;

  for (genvar g = 0; g < 2; g++) begin : g_proc
    pmm_pkg::pmm_req_t  rq;
    pmm_pkg::pmm_resp_t resp_d;
    pmm_pkg::pmm_resp_t resp_q;
    logic [MW-1:0] eff_map;
    logic [4:0]    lpage;
    logic [1:0]    tgt;
    logic          to_mapram;
    logic          in_periph;
    logic          map_wr;
    logic [EW-1:0] entry;

    assign rq    = proc_req[g];
    assign lpage = rq.addr[15:11];
    assign tgt   = rq.addr[pmm_pkg::TGT_LSB +: 2];
    assign eff_map = state_q[g] ? map_b_q[g] : map_a_q[g];
    assign rd_idx[g] = {eff_map, lpage};
    assign entry     = rd_data[g];
    assign pdis_cur[g] = pdis_q[eff_map];
    assign gfx_cur[g]  = gfxen_q[eff_map];

    // disabled peripherals fall through to RAM
    assign in_periph = pen_s[g] &&
                       rq.addr[15:13] == pmm_pkg::PERIPH_TOP3;
    // map range is a peripheral too
    assign to_mapram = pen_s[g] && lpage == pmm_pkg::MAPRAM_LPAGE;
    assign map_wr = rq.valid && rq.write && to_mapram;

    assign wr_en[2*g]   = map_wr &&
                          (tgt == pmm_pkg::TGT_ALL || tgt == pmm_pkg::TGT_A);
    assign wr_en[2*g+1] = map_wr &&
                          (tgt == pmm_pkg::TGT_ALL || tgt == pmm_pkg::TGT_B);
    assign wr_idx[2*g]    = {map_a_q[g], rq.addr[4:0]};
    assign wr_idx[2*g+1]  = {map_b_q[g], rq.addr[4:0]};
    assign wr_data[2*g]   = rq.wdata;
    assign wr_data[2*g+1] = rq.wdata;

    always_comb begin
      resp_d            = '0;
      resp_d.valid      = rq.valid;
      resp_d.map_wr     = map_wr;
      resp_d.periph_sel = rq.valid && in_periph;
      resp_d.gfx_sel    = rq.valid && gfx_cur[g] &&
                          rq.addr[15:14] == pmm_pkg::GFX_TOP2;
      resp_d.ram_sel    = rq.valid && !in_periph && !resp_d.gfx_sel;
      resp_d.card_hit   = resp_d.ram_sel &&
                          entry[pmm_pkg::CARD_BIT] == card_s;
      resp_d.phys_addr  = {entry[pmm_pkg::PPAGE_W-1:0],
                           rq.addr[pmm_pkg::OFFSET_W-1:0]};
    end

    // each port answers every cycle, no arbitration
    always_ff @(posedge mclk) begin
      if (reset) begin
        resp_q <= '0;
      end else begin
        resp_q <= resp_d;
      end
    end

    assign proc_resp[g] = resp_q;
  end

  // ----------------------------------------------------------------
  // card zero enable outputs
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      periph_enable_out   <= 2'h3;
      graphics_ram_enable <= 2'h0;
    end else begin
      periph_enable_out   <= ~pdis_cur;
      graphics_ram_enable <= gfx_cur;
    end
  end

  assign periph_enable_oe       = !card_s;
  assign graphics_ram_enable_oe = !card_s;

  // ----------------------------------------------------------------
  // dma port
  // ----------------------------------------------------------------
  logic          claim_any;
  logic [MW-1:0] dma_map;
  pmm_pkg::pmm_resp_t dma_d;

  always_comb begin
    claim_any = 1'b0;
    dma_map   = '0;
    for (int c = DMA_CH - 1; c >= 0; c--) begin
      if (claim_s[c]) begin
        claim_any = 1'b1;
        dma_map   = dmamap_q[c];
      end
    end
  end

  assign rd_idx[2] = {dma_map, dma_addr[15:11]};

  always_comb begin
    dma_d           = '0;
    dma_d.valid     = dma_valid;
    dma_d.ram_sel   = dma_valid && claim_any;
    dma_d.card_hit  = dma_d.ram_sel &&
                      rd_data[2][pmm_pkg::CARD_BIT] == card_s;
    dma_d.phys_addr = {rd_data[2][pmm_pkg::PPAGE_W-1:0],
                       dma_addr[pmm_pkg::OFFSET_W-1:0]};
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      dma_resp <= '0;
    end else begin
      dma_resp <= dma_d;
    end
  end

endmodule : pmm_mapper
`default_nettype wire

// File: pmm_mapper_asserts.sv
// port checker for the paged memory mapper
`timescale 1ns/1ps
`default_nettype none
module pmm_mapper_asserts #(
  parameter int DMA_CH = 3
) (
  input wire logic               mclk,
  input wire logic               reset,
  input wire pmm_pkg::pmm_req_t  proc_req [2],
  input wire pmm_pkg::pmm_resp_t proc_resp [2],
  input wire logic               dma_valid,
  input wire pmm_pkg::pmm_resp_t dma_resp,
  input wire logic [DMA_CH-1:0]  dma_claim,
  input wire logic               card_id_pin,
  input wire logic               periph_enable_oe,
  input wire logic               graphics_ram_enable_oe
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  property p_resp_valid;
    proc_req[1].valid |=> proc_resp[1].valid;
  endproperty
  a_resp_valid: assert property (p_resp_valid)
    else $error("resp missing");
  property p_offset;
    proc_req[0].valid |=>
      proc_resp[0].phys_addr[10:0] == $past(proc_req[0].addr[10:0]);
  endproperty
  a_offset: assert property (p_offset)
    else $error("offset bad");
  property p_gfx_win;
    proc_req[0].valid && proc_req[0].addr[15:14] != 2'h2
      |=> !proc_resp[0].gfx_sel;
  endproperty
  a_gfx_win: assert property (p_gfx_win)
    else $error("gfx out");
  property p_periph_win;
    proc_req[1].valid && proc_req[1].addr[15:13] != 3'h7
      |=> !proc_resp[1].periph_sel;
  endproperty
  a_periph_win: assert property (p_periph_win)
    else $error("periph");
  property p_map_wr;
    proc_req[0].valid && (!proc_req[0].write ||
      proc_req[0].addr[15:11] != 5'h1e) |=> !proc_resp[0].map_wr;
  endproperty
  a_map_wr: assert property (p_map_wr)
    else $error("map write");
  property p_pen_oe;
    (!card_id_pin)[*4] |-> periph_enable_oe;
  endproperty
  a_pen_oe: assert property (p_pen_oe)
    else $error("pen oe");
  property p_gfx_oe;
    card_id_pin[*4] |-> !graphics_ram_enable_oe;
  endproperty
  a_gfx_oe: assert property (p_gfx_oe)
    else $error("gfx oe");
  property p_dma_idle;
    (dma_claim == '0)[*4] ##0 dma_valid |=> !dma_resp.ram_sel;
  endproperty
  a_dma_idle: assert property (p_dma_idle)
    else $error("dma idle");
  property p_dma_ram;
    dma_valid |=> !dma_resp.periph_sel && !dma_resp.gfx_sel;
  endproperty
  a_dma_ram: assert property (p_dma_ram)
    else $error("dma decode");
endmodule : pmm_mapper_asserts
bind pmm_mapper pmm_mapper_asserts #(.DMA_CH(DMA_CH)) u_chk (
  .mclk(mclk), .reset(reset), .proc_req(proc_req),
  .proc_resp(proc_resp), .dma_valid(dma_valid), .dma_resp(dma_resp),
  .dma_claim(dma_claim), .card_id_pin(card_id_pin),
  .periph_enable_oe(periph_enable_oe),
  .graphics_ram_enable_oe(graphics_ram_enable_oe)
);
`default_nettype wire

// File: pmm_far_model.sv
// far side model: shared enable line with pull-ups, dma claim lines
`timescale 1ns/1ps
`default_nettype none
module pmm_far_model #(
  parameter int DMA_CH = 3
) (
  input  wire logic              mclk,
  input  wire logic [DMA_CH-1:0] claim_req,
  input  wire logic [1:0]        periph_enable_out,
  input  wire logic              periph_enable_oe,
  output logic      [1:0]        peripheral_enable_input,
  output logic      [DMA_CH-1:0] dma_claim
);
  assign peripheral_enable_input = periph_enable_oe ? periph_enable_out : 2'h3;
  always_ff @(posedge mclk) dma_claim <= claim_req;
endmodule : pmm_far_model
`default_nettype wire

// File: pmm_mapper_tb.sv
// self-checking bench for the paged memory mapper
`timescale 1ns/1ps
`default_nettype none
module pmm_mapper_tb;
  typedef struct {pmm_pkg::pmm_resp_t e; logic full;} pmm_note_t;
  logic               mclk, reset, psel, penable, pwrite, pready, pslverr;
  logic [7:0]         paddr;
  logic [31:0]        pwdata, prdata, o;
  logic [23:0]        m;
  pmm_pkg::pmm_req_t  proc_req [2];
  pmm_pkg::pmm_resp_t proc_resp [2], dma_resp, r;
  logic [1:0]         irq_taken, pen_in, pen_out, gfx_en;
  logic               dma_valid, card_id_pin, pen_oe, gfx_oe;
  logic [15:0]        dma_addr;
  logic [2:0]         claim_req, dma_claim;
  pmm_note_t          q[3][$], n;
  int                 err_count, num_checks, seed;

  pmm_mapper #(.DMA_CH(3)) DUT (
    .mclk(mclk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .proc_req(proc_req),
    .proc_resp(proc_resp), .irq_taken(irq_taken), .dma_valid(dma_valid),
    .dma_addr(dma_addr), .dma_resp(dma_resp), .dma_claim(dma_claim),
    .card_id_pin(card_id_pin), .peripheral_enable_input(pen_in),
    .periph_enable_out(pen_out), .periph_enable_oe(pen_oe),
    .graphics_ram_enable(gfx_en), .graphics_ram_enable_oe(gfx_oe));
  pmm_far_model #(.DMA_CH(3)) u_far (
    .mclk(mclk), .claim_req(claim_req), .periph_enable_out(pen_out),
    .periph_enable_oe(pen_oe), .peripheral_enable_input(pen_in),
    .dma_claim(dma_claim));

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic end_of_test;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_of_test
  task automatic chk(input string s, input logic [31:0] e, g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, e, input logic se);
    int k;
    @(posedge mclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    psel    <= 1'b0;
    penable <= 1'b0;
    if (k >= 16) begin
      chk("pready", 1, 0);
      end_of_test();
    end
    chk("pslverr", {31'h0, se}, {31'h0, pslverr});
    if (!w) chk("prdata", e, prdata);
  endtask : apb
  function automatic pmm_pkg::pmm_resp_t ex(logic [3:0] f, logic [6:0] pg,
                                            logic [10:0] of);
    // f is map_wr, ram_sel, periph_sel, gfx_sel; card zero entries
    ex = {1'b1, f[3], f[2], f[2], f[1], f[0], pg, of};
  endfunction : ex
  task automatic acc(input int p, input logic w, input logic [15:0] a,
                     input logic [7:0] d, input pmm_pkg::pmm_resp_t e,
                     input logic full);
    @(posedge mclk);
    if (p == 2) begin
      dma_valid <= 1'b1;
      dma_addr  <= a;
    end else proc_req[p] <= '{1'b1, w, a, d};
    q[p].push_back('{e, full});
    @(posedge mclk);
    if (p == 2) dma_valid <= 1'b0;
    else proc_req[p].valid <= 1'b0;
  endtask : acc
  task automatic irq;
    @(posedge mclk);
    irq_taken <= 2'h2;
    @(posedge mclk);
    irq_taken <= 2'h0;
  endtask : irq
  // responses checked against the oldest note of their port
  always @(negedge mclk) begin
    if (!reset) begin
      for (int p = 0; p < 3; p++) begin
        r = (p == 2) ? dma_resp : proc_resp[p];
        if (r.valid === 1'b1 && q[p].size() == 0) chk("resp_extra", 0, 1);
        else if (r.valid === 1'b1) begin
          n = q[p].pop_front();
          m = n.full ? 24'hffffff : 24'hec0000;
          chk("resp", {8'h0, n.e & m}, {8'h0, r & m});
        end
      end
    end
  end
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 1;
    {psel, penable, pwrite, dma_valid, card_id_pin} = 5'h0;
    {paddr, pwdata, irq_taken, dma_addr, claim_req} = '0;
    proc_req[0] = '0;
    proc_req[1] = '0;
    reset = 1'b1;
    repeat (5) @(posedge mclk);
    reset <= 1'b0;
    repeat (2) @(posedge mclk);
    for (int a = 0; a < 24; a += 4) apb(0, 8'(a), 0, 0, 0);
    apb(0, pmm_pkg::REG_STATUS, 0, 32'h30, 0);
    apb(1, 8'h1c, 1, 0, 1);
    apb(0, 8'h1c, 0, 0, 1);
    for (int i = 0; i < 32; i++) begin
      apb(1, pmm_pkg::REG_P1MAP, i, 0, 0);
      acc(0, 1, 16'hf028, 8'(i + 8), ex(4'ha, 0, 0), 0);
    end
    for (int i = 0; i < 32; i++) begin
      o = $random(seed);
      apb(1, pmm_pkg::REG_P1MAP, i, 0, 0);
      acc(0, 0, {5'h08, o[10:0]}, 0, ex(4'h4, 7'(i+8), o[10:0]), 1);
    end
    apb(1, pmm_pkg::REG_P2MAP, 32'h1d1c, 0, 0);
    acc(1, 1, 16'hf028, 8'h01, ex(4'ha, 0, 0), 0);
    acc(1, 1, 16'hf048, 8'h02, ex(4'ha, 0, 0), 0);
    acc(1, 1, 16'hf05e, 8'h09, ex(4'ha, 0, 0), 0);
    acc(1, 1, 16'hf05c, 8'h0a, ex(4'ha, 0, 0), 0);
    acc(1, 0, 16'h4123, 0, ex(4'h4, 7'h1, 11'h123), 1);
    apb(1, pmm_pkg::REG_STATE, 2, 0, 0);
    acc(1, 0, 16'h4123, 0, ex(4'h4, 7'h2, 11'h123), 1);
    acc(1, 1, 16'h4055, 8'hbb, ex(4'h4, 7'h2, 11'h055), 1);
    irq();
    apb(0, pmm_pkg::REG_STATE, 0, 0, 0);
    fork
      acc(0, 0, 16'h4123, 0, ex(4'h4, 7'h27, 11'h123), 1);
      acc(1, 1, 16'h4123, 8'h11, ex(4'h4, 7'h1, 11'h123), 1);
    join
    fork
      acc(0, 1, 16'hf028, 8'h27, ex(4'ha, 0, 0), 0);
      acc(1, 0, 16'h4777, 0, ex(4'h4, 7'h1, 11'h777), 1);
    join
    apb(1, pmm_pkg::REG_PDIS, 32'h2000_0000, 0, 0);
    apb(1, pmm_pkg::REG_STATE, 2, 0, 0);
    repeat (5) @(posedge mclk);
    chk("pen_out", 1, pen_out);
    apb(0, pmm_pkg::REG_STATUS, 0, 32'h10, 0);
    acc(1, 0, 16'he010, 0, ex(4'h4, 7'h0a, 11'h010), 1);
    acc(1, 1, 16'hf048, 8'h08, ex(4'h4, 7'h09, 11'h048), 1);
    acc(1, 0, 16'h4000, 0, ex(4'h4, 7'h02, 11'h000), 1);
    irq();
    repeat (5) @(posedge mclk);
    acc(1, 0, 16'he010, 0, ex(4'h2, 0, 0), 0);
    apb(1, pmm_pkg::REG_GFXEN, 32'h8000_0000, 0, 0);
    acc(0, 0, 16'h8abc, 0, ex(4'h1, 0, 0), 0);
    chk("gfx_en", 1, gfx_en[0]);
    apb(1, pmm_pkg::REG_P1MAP, 30, 0, 0);
    acc(0, 1, 16'h8abc, 8'h5a, ex(4'h4, 0, 0), 0);
    chk("gfx_en", 0, gfx_en[0]);
    apb(1, pmm_pkg::REG_DMAMAP, 32'h3e0, 0, 0);
    claim_req <= 3'h2;
    repeat (4) @(posedge mclk);
    acc(2, 0, 16'h4007, 0, ex(4'h4, 7'h27, 11'h007), 1);
    claim_req <= 3'h3;
    repeat (4) @(posedge mclk);
    acc(2, 0, 16'h4007, 0, ex(4'h4, 7'h08, 11'h007), 1);
    claim_req <= 3'h0;
    repeat (4) @(posedge mclk);
    acc(2, 0, 16'h4007, 0, ex(4'h0, 0, 0), 0);
    chk("pen_oe", 1, pen_oe);
    chk("gfx_oe", 1, gfx_oe);
    card_id_pin <= 1'b1;
    repeat (4) @(posedge mclk);
    chk("pen_oe", 0, pen_oe);
    chk("gfx_oe", 0, gfx_oe);
    apb(0, pmm_pkg::REG_STATUS, 0, 32'h31, 0);
    acc(1, 0, 16'h4000, 0, ex(4'h4, 7'h01, 11'h0) ^ 24'h100000, 1);
    repeat (3) @(posedge mclk);
    for (int p = 0; p < 3; p++) chk("pending", 0, q[p].size());
    end_of_test();
  end
endmodule : pmm_mapper_tb
`default_nettype wire
